/* File: dv/encoder_source.sv */
`timescale 1ns/10ps
module encoder_source #(
  parameter int STEP = 5  // Cycles per quadrature state; one channel A period is 4*STEP.
) (
  input  wire logic       clk_sys,
  input  wire logic       inverse,
  input  wire logic       brk1,
  input  wire logic       brk2,
  input  wire logic       quad,
  input  wire logic       dbrk,
  input  wire logic       hold,
  output logic      [3:0] strip,
  output logic      [3:0] diff1,
  output logic      [3:0] diff2,
  output logic            sin_sign,
  output logic            cos_sign
);
  int unsigned cnt = 0;     // Divider for the quadrature phase.
  logic [1:0]  ph  = 2'h0;  // Gray-stepped phase of both channels.
  logic        a;
  logic        b;
  // Encoder phase advances steadily while hold is low, also between tests.
  always @(posedge clk_sys) begin
    cnt <= (cnt == STEP - 1) ? 0 : cnt + 1;
    // A held phase gives static levels for the direction inputs.
    if (!hold && cnt == STEP - 1) ph <= ph + 2'h1;
  end
  assign a = ph[1];
  assign b = ph[1] ^ ph[0];
  assign strip = quad ? {b, a, b, a} : {a ^ inverse ^ brk2, a, a ^ inverse ^ brk1, a};
  assign diff1 = {a, ~a ^ dbrk, b, ~b};
  assign diff2 = {a, ~a, b, ~b};
  assign sin_sign = a;
  assign cos_sign = b;
endmodule

/* File: dv/safety_io_assertions.sv */
`timescale 1ns/10ps
module safety_io_assertions
  import safety_io_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        analog_loop_open,
  input wire logic        sine_cosine_splitter_offset_shift,
  input wire logic [3:0]  square_wave_out,
  input wire logic [3:0]  square_wave_oe,
  input wire logic [11:0] analog_current_code,
  input wire logic [3:0]  control_output_strip
);
  // The offset shift follows the latched error, so it marks the safe state.
  logic err;
  assign err = sine_cosine_splitter_offset_shift;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  property p_bus_wait;
    (avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("bus wait state wrong");
  property p_sq_safe;
    err |-> square_wave_oe == 4'h0 && square_wave_out == 4'h0;
  endproperty
  a_sq_safe: assert property (p_sq_safe) else $error("square drivers active in error");
  property p_an_zero;
    err |-> analog_current_code == DAC_ZERO;
  endproperty
  a_an_zero: assert property (p_an_zero) else $error("analog not zero in error");
  property p_ctl_low;
    err |-> control_output_strip == 4'h0;
  endproperty
  a_ctl_low: assert property (p_ctl_low) else $error("control outputs high in error");
  property p_an_range;
    $changed(analog_current_code) && !err |-> analog_current_code >= DAC_4MA;
  endproperty
  a_an_range: assert property (p_an_range) else $error("analog below live range");
  property p_loop_err;
    analog_loop_open [*2] |-> ##[1:6] err;
  endproperty
  a_loop_err: assert property (p_loop_err) else $error("open loop not flagged");
  property p_err_hold;
    err && !avs_write |=> err;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error dropped without clear");
  property p_sq_pair;
    !err && square_wave_oe == 4'hf |-> square_wave_out[3] != square_wave_out[2];
  endproperty
  a_sq_pair: assert property (p_sq_pair) else $error("square pair not complementary");
endmodule

bind safety_io safety_io_assertions i_chk (.clk_sys, .srst, .avs_read, .avs_write,
  .avs_waitrequest, .analog_loop_open, .sine_cosine_splitter_offset_shift, .square_wave_out,
  .square_wave_oe, .analog_current_code, .control_output_strip);

/* File: dv/tb_safety_io.sv */
`timescale 1ns/10ps
module tb_safety_io;
  import safety_io_pkg::*;
  localparam int GATE = 200;  // Short gate keeps the run brief.
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic        avs_waitrequest, sin_s, cos_s, sc_en, off_sh;
  logic [3:0]  strip, diff1, diff2, sq_out, sq_oe, ctl_out;
  logic        sc_fault = 1'b0, loop_open = 1'b0;
  logic        inverse = 1'b0, brk1 = 1'b0, brk2 = 1'b0, quad = 1'b0, dbrk = 1'b0;
  logic        hold = 1'b0;
  logic [11:0] an_code;
  int          miscompares = 0, check_count = 0;

  safety_io #(.GATE_LEN(GATE)) i_dut (.clk_sys, .srst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .control_input_strip(strip),
    .differential_input_connector_one(diff1), .differential_input_connector_two(diff2),
    .sine_cosine_input_sin_sign(sin_s), .sine_cosine_input_cos_sign(cos_s),
    .sine_cosine_input_fault(sc_fault), .analog_loop_open(loop_open),
    .sine_cosine_splitter_enable(sc_en), .sine_cosine_splitter_offset_shift(off_sh),
    .square_wave_out(sq_out), .square_wave_oe(sq_oe), .analog_current_code(an_code),
    .control_output_strip(ctl_out));
  encoder_source i_src (.clk_sys, .inverse, .brk1, .brk2, .quad, .dbrk, .hold, .strip, .diff1,
    .diff2, .sin_sign(sin_s), .cos_sign(cos_s));

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic finish_test;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One Avalon access; the request is held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    if (n >= 20) begin
      miscompares++;
      finish_test();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  function automatic logic [31:0] ctrl(input logic [3:0] op, input logic [2:0] sm);
    return {8'h00, FILT_LEN_RST, 8'h00, 1'b0, sm, op};
  endfunction

  // Lets faults settle through sync and filter, then judges status and safe outputs.
  task automatic probe(input logic [5:0] exp, input logic safe);
    repeat (40) @(posedge clk_sys);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("status", {26'h0, exp}, {26'h0, rd[5:0]});
    if (safe) check("safe outputs", 32'h0100_0000, {7'h0, off_sh, sq_out, sq_oe, an_code, ctl_out});
  endtask

  task automatic clear;
    // Released pins first pass the synchronisers, so no live fault outlasts the clear.
    repeat (4) @(posedge clk_sys);
    wr(ADDR_ERR_CLEAR, 32'h1);
    probe(6'h00, 1'b0);
  endtask

  task automatic t_reset;
    bus(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl", 32'h0004_0040, rd);
    bus(1'b0, ADDR_AN_END, 32'h0);
    check("analog end", 32'h0000_ffff, rd);
    wr(6'h3c, 32'h5a5a_5a5a);
    bus(1'b0, 6'h3c, 32'h0);
    check("unmapped", 32'h0, rd);
    check("splitter enable", 32'h1, {31'h0, sc_en});
  endtask

  task automatic t_freq;
    logic [31:0] e;
    logic        s;
    quad <= 1'b1;
    wr(ADDR_CTRL, ctrl(4'h3, STRIP_QUAD));
    wr(ADDR_AN_END, 32'd20);
    wr(ADDR_SWITCH0, 32'd5);
    wr(ADDR_SWITCH0 + 6'h4, 32'd20);
    wr(ADDR_SWITCH0 + 6'h8, 32'd20);
    wr(ADDR_SWITCH3, 32'hffff);
    wr(ADDR_OUT_CFG, 32'h102);
    repeat (3 * GATE) @(posedge clk_sys);
    bus(1'b0, ADDR_FREQ1, 32'h0);
    check("freq one", 32'd10, rd);
    bus(1'b0, ADDR_FREQ2, 32'h0);
    check("freq two", 32'd10, rd);
    check("analog", 32'h999, {20'h0, an_code});
    check("control", 32'h4, {28'h0, ctl_out});
    check("square enable", 32'hf, {28'h0, sq_oe});
    e = 0;
    s = sq_out[3];
    for (int k = 0; k < GATE; k++) begin
      @(posedge clk_sys);
      e += 32'(sq_out[3] && !s);
      s = sq_out[3];
    end
    check("square edges", 32'd10, e);
    wr(ADDR_AN_END, 32'd10);
    repeat (GATE + 60) @(posedge clk_sys);
    check("analog top", 32'hfff, {20'h0, an_code});
  endtask

  task automatic t_pairs;
    logic [2:0] md [5];
    logic       p1, p2;
    md = '{STRIP_INVERSE, STRIP_HOMOG, STRIP_MIX_HOM, STRIP_MIX_INV, STRIP_FOUR};
    quad <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      p1 = md[i] != STRIP_FOUR;
      p2 = md[i] == STRIP_INVERSE || md[i] == STRIP_HOMOG;
      wr(ADDR_CTRL, ctrl(4'h3, STRIP_FOUR));
      inverse <= md[i] == STRIP_INVERSE || md[i] == STRIP_MIX_INV;
      wr(ADDR_CTRL, ctrl(4'h3, md[i]));
      probe(6'h00, 1'b0);
      brk1 <= 1'b1;
      probe({4'h0, p1, p1}, p1);
      brk1 <= 1'b0;
      clear();
      brk2 <= 1'b1;
      probe({3'h0, p2, 1'b0, p2}, p2);
      brk2 <= 1'b0;
      clear();
    end
  endtask

  // Single-channel mode: inputs two and four read back as static directions.
  task automatic t_single;
    quad <= 1'b0;
    hold <= 1'b1;
    brk1 <= 1'b1;
    wr(ADDR_CTRL, ctrl(4'h3, STRIP_SINGLE));
    probe(6'h00, 1'b0);
    check("direction", {24'h0, strip, strip[3], strip[1]}, {24'h0, rd[11:6]});
    brk1 <= 1'b0;
    hold <= 1'b0;
  endtask

  task automatic t_faults;
    logic [3:0] op [3];
    op = '{4'h3, 4'h7, 4'h0};
    quad <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTRL, ctrl(op[i], STRIP_QUAD));
      probe(6'h00, 1'b0);
      check("splitter enable", {31'h0, i == 2}, {31'h0, sc_en});
      loop_open <= i == 0;
      sc_fault <= i == 2;
      dbrk <= i == 1;
      probe(6'h1 | (6'h8 << i), 1'b1);
      wr(ADDR_ERR_CLEAR, 32'h1);
      probe(6'h1 | (6'h8 << i), 1'b1);
      loop_open <= 1'b0;
      sc_fault <= 1'b0;
      dbrk <= 1'b0;
      clear();
    end
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_freq();
    t_pairs();
    t_single();
    t_faults();
    finish_test();
  end
endmodule

/* File: rtl/safety_io.sv */
// Function
// - Differential incremental inputs used in modes 7-9.
// - Zero or index pulses are never evaluated.
// - Quadrature strip: two A/B frequency sensors.
// - Single-channel strip: second input gives direction.
// - Inverse pairs must be complementary, else error.
// - Homogeneous pairs must match, else error.
// - Four independent control inputs, no pair check.
// - Mixed: pair one checked, inputs three, four single.
// - Sine/cosine modes forward input one downstream.
// - Error shifts sine/cosine splitter DC offset.
// - Square splitter repeats selected sensor frequency.
// - Square splitter always square, one pulse per period.
// - Error stops square splitter, drivers go high-impedance.
// - Sine/cosine input fault may fault square splitter.
// - Analog output scaled 4-20 mA between start, end.
// - Error drives analog output to zero current.
// - Open analog loop raises the error state.
// - Control outputs switch on programmable points, invertible.
// - Error forces all control outputs low.
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
module safety_io
  import safety_io_pkg::*;
#(
  parameter int GATE_LEN = GATE_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [3:0]  control_input_strip,
  input  wire logic [3:0]  differential_input_connector_one,
  input  wire logic [3:0]  differential_input_connector_two,
  input  wire logic        sine_cosine_input_sin_sign,
  input  wire logic        sine_cosine_input_cos_sign,
  input  wire logic        sine_cosine_input_fault,
  input  wire logic        analog_loop_open,
  output logic             sine_cosine_splitter_enable,
  output logic             sine_cosine_splitter_offset_shift,
  output logic [3:0]       square_wave_out,
  output logic [3:0]       square_wave_oe,
  output logic [11:0]      analog_current_code,
  output logic [3:0]       control_output_strip
);

  state_t      st_reg;          // Registered state.
  state_t      st_next;         // Next state.
  pins_t       pins_raw;        // Pins gathered into one word.
  logic [1:0]  sens_a;          // Channel A of sensors 1 and 2.
  logic [1:0]  sens_b;          // Channel B of sensors 1 and 2.
  logic [1:0]  pair_bad;        // Raw pair relation violations.
  logic [4:0]  fault_now;       // Live fault sources.
  logic [15:0] an_freq;         // Frequency feeding the analog output.
  logic        sel_freq_hi;     // Control output comparison result.
  logic [15:0] sel_freq;        // Frequency seen by one control output.
  logic        req;             // Bus request present.
  logic [31:0] gate_last;       // Final count of the gate window.

  // Sine/cosine operational modes.
  function automatic logic is_sincos(input logic [3:0] m);
    return (m == 4'h0) || (m == 4'h1) || (m == 4'h2) || (m == 4'h6);
  endfunction

  // Differential incremental operational modes.
  function automatic logic is_diff(input logic [3:0] m);
    return (m == 4'h7) || (m == 4'h8) || (m == 4'h9);
  endfunction

  // Pair relation check: inverse pairs must differ, homogeneous pairs must match.
  function automatic logic pair_viol(input logic inv, input logic x, input logic y);
    return inv ? (x == y) : (x != y);
  endfunction

  // Saturating sixteen-bit increment so long windows never wrap to a low reading.
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == 16'hffff) ? v : v + 16'h0001;
  endfunction

  assign pins_raw = '{strip: control_input_strip,
                      diff1: differential_input_connector_one,
                      diff2: differential_input_connector_two,
                      sin_sign: sine_cosine_input_sin_sign,
                      cos_sign: sine_cosine_input_cos_sign,
                      sincos_fault: sine_cosine_input_fault,
                      loop_open: analog_loop_open};
  // Either strobe opens an access; the master never raises both at once.
  assign req       = avs_read | avs_write;
  assign gate_last = 32'(GATE_LEN - 1);

  // Sensor routing: only channel A and B are taken; any index line is never wired in.
  always_comb begin
    if (is_sincos(st_reg.op_mode)) begin
      sens_a[0] = st_reg.sync2.sin_sign;
      sens_b[0] = st_reg.sync2.cos_sign;
    end else if (is_diff(st_reg.op_mode)) begin
      sens_a[0] = st_reg.sync2.diff1[3];
      sens_b[0] = st_reg.sync2.diff1[1];
    end else begin
      sens_a[0] = st_reg.sync2.strip[0];
      sens_b[0] = st_reg.sync2.strip[1];
    end
    if (is_diff(st_reg.op_mode)) begin
      sens_a[1] = st_reg.sync2.diff2[3];
      sens_b[1] = st_reg.sync2.diff2[1];
    end else begin
      sens_a[1] = st_reg.sync2.strip[2];
      sens_b[1] = st_reg.sync2.strip[3];
    end
  end

  // Live fault sources, with the mismatch filter applied to the pairs.
  always_comb begin
    pair_bad = 2'b00;
    case (st_reg.strip_mode)
      STRIP_INVERSE: begin
        pair_bad[0] = pair_viol(1'b1, st_reg.sync2.strip[0], st_reg.sync2.strip[1]);
        pair_bad[1] = pair_viol(1'b1, st_reg.sync2.strip[2], st_reg.sync2.strip[3]);
      end
      STRIP_HOMOG: begin
        pair_bad[0] = pair_viol(1'b0, st_reg.sync2.strip[0], st_reg.sync2.strip[1]);
        pair_bad[1] = pair_viol(1'b0, st_reg.sync2.strip[2], st_reg.sync2.strip[3]);
      end
      STRIP_MIX_HOM: begin
        pair_bad[0] = pair_viol(1'b0, st_reg.sync2.strip[0], st_reg.sync2.strip[1]);
      end
      STRIP_MIX_INV: begin
        pair_bad[0] = pair_viol(1'b1, st_reg.sync2.strip[0], st_reg.sync2.strip[1]);
      end
      default: begin
        pair_bad = 2'b00;
      end
    endcase
    fault_now[0] = (st_reg.mis1 >= st_reg.filt_len) && pair_bad[0];
    fault_now[1] = (st_reg.mis2 >= st_reg.filt_len) && pair_bad[1];
    fault_now[2] = st_reg.sync2.loop_open;
    fault_now[3] = is_diff(st_reg.op_mode) &&
                   ((st_reg.sync2.diff1[3] == st_reg.sync2.diff1[2]) ||
                    (st_reg.sync2.diff1[1] == st_reg.sync2.diff1[0]) ||
                    (st_reg.sync2.diff2[3] == st_reg.sync2.diff2[2]) ||
                    (st_reg.sync2.diff2[1] == st_reg.sync2.diff2[0]));
    fault_now[4] = is_sincos(st_reg.op_mode) && st_reg.sync2.sincos_fault;
  end

  // Next state: synchronisers, frequency gate, bus slave, scaling and outputs.
  always_comb begin
    st_next = st_reg;
    an_freq = 16'h0000;
    sel_freq = 16'h0000;
    sel_freq_hi = 1'b0;

    // Two flip-flops on every pin before any logic looks at it.
    st_next.sync1 = pins_raw;
    st_next.sync2 = st_reg.sync1;

    // Pair mismatch counters reset as soon as the relation holds again.
    st_next.mis1 = pair_bad[0] ? ((st_reg.mis1 == 8'hff) ? 8'hff : st_reg.mis1 + 8'h01) : 8'h00;
    st_next.mis2 = pair_bad[1] ? ((st_reg.mis2 == 8'hff) ? 8'hff : st_reg.mis2 + 8'h01) : 8'h00;

    // Rising edges of channel A counted over a fixed gate window.
    st_next.prev_a = sens_a;
    if (sens_a[0] && !st_reg.prev_a[0]) begin
      st_next.cnt1 = sat_inc(st_reg.cnt1);
    end
    if (sens_a[1] && !st_reg.prev_a[1]) begin
      st_next.cnt2 = sat_inc(st_reg.cnt2);
    end
    if (st_reg.gate >= gate_last) begin
      st_next.gate = 32'h0000_0000;
      st_next.freq1 = st_next.cnt1;
      st_next.freq2 = st_next.cnt2;
      st_next.cnt1 = 16'h0000;
      st_next.cnt2 = 16'h0000;
      an_freq = st_reg.an_src ? st_next.freq2 : st_next.freq1;
      if (an_freq <= st_reg.an_start || st_reg.an_end <= st_reg.an_start) begin
        st_next.an_val = DAC_4MA;
      end else if (an_freq >= st_reg.an_end) begin
        st_next.an_val = DAC_20MA;
      end else begin
        // Division runs serially, trading latency within the window for area.
        st_next.div_busy = 1'b1;
        st_next.div_cnt = DIV_STEPS;
        st_next.num = 28'(32'(an_freq - st_reg.an_start) * 32'(DAC_SPAN));
        st_next.den = st_reg.an_end - st_reg.an_start;
        st_next.rem = 17'h00000;
        st_next.quo = 28'h0000000;
      end
    end else begin
      st_next.gate = st_reg.gate + 32'h0000_0001;
    end

    // One restoring division step per clock.
    if (st_reg.div_busy) begin
      st_next.rem = {st_reg.rem[15:0], st_reg.num[27]};
      st_next.num = {st_reg.num[26:0], 1'b0};
      st_next.quo = {st_reg.quo[26:0], 1'b0};
      if (st_next.rem >= {1'b0, st_reg.den}) begin
        st_next.rem = st_next.rem - {1'b0, st_reg.den};
        st_next.quo[0] = 1'b1;
      end
      st_next.div_cnt = st_reg.div_cnt - 5'h01;
      if (st_reg.div_cnt == 5'h01) begin
        st_next.div_busy = 1'b0;
        st_next.an_val = DAC_4MA + st_next.quo[11:0];
      end
    end

    st_next.cause = st_reg.cause | fault_now;
    // A clear only takes causes that are gone; a live fault wins over the clear.
    if (avs_write && st_reg.ack && avs_address == ADDR_ERR_CLEAR && avs_writedata[0]) begin
      st_next.cause = fault_now;
    end
    // The error flag is a plain OR of the latched causes, so it never drifts from them.
    st_next.err = |st_next.cause;

    // Avalon slave: one wait state, read data prepared while waitrequest is high.
    st_next.ack = req && !st_reg.ack;
    if (avs_read && !st_reg.ack) begin
      case (avs_address)
        ADDR_CTRL:     st_next.rdata = {8'h00, st_reg.filt_len, 7'h00, st_reg.an_src,
                                        st_reg.sq_src, st_reg.strip_mode, st_reg.op_mode};
        ADDR_STATUS: begin
          // Inputs two and four only mean a direction in single-channel mode.
          if (st_reg.strip_mode == STRIP_SINGLE) begin
            st_next.rdata = {20'h00000, st_reg.sync2.strip, st_reg.sync2.strip[3],
                             st_reg.sync2.strip[1], st_reg.cause, st_reg.err};
          end else begin
            st_next.rdata = {20'h00000, st_reg.sync2.strip, 2'h0, st_reg.cause, st_reg.err};
          end
        end
        ADDR_AN_START: st_next.rdata = {16'h0000, st_reg.an_start};
        ADDR_AN_END:   st_next.rdata = {16'h0000, st_reg.an_end};
        ADDR_FREQ1:    st_next.rdata = {16'h0000, st_reg.freq1};
        ADDR_FREQ2:    st_next.rdata = {16'h0000, st_reg.freq2};
        ADDR_OUT_CFG:  st_next.rdata = {20'h00000, st_reg.out_cfg};
        default: begin
          if (avs_address >= ADDR_SWITCH0 && avs_address <= ADDR_SWITCH3 &&
              avs_address[1:0] == 2'b00) begin
            st_next.rdata = {16'h0000, st_reg.sw_pt[avs_address[3:2]]};
          end else begin
            st_next.rdata = 32'h0000_0000;
          end
        end
      endcase
    end
    if (avs_write && st_reg.ack) begin
      case (avs_address)
        ADDR_CTRL: begin
          st_next.op_mode = avs_writedata[3:0];
          st_next.strip_mode = avs_writedata[6:4];
          st_next.sq_src = avs_writedata[7];
          st_next.an_src = avs_writedata[8];
          st_next.filt_len = avs_writedata[23:16];
        end
        ADDR_AN_START: st_next.an_start = avs_writedata[15:0];
        ADDR_AN_END:   st_next.an_end = avs_writedata[15:0];
        ADDR_OUT_CFG:  st_next.out_cfg = avs_writedata[11:0];
        default: begin
          if (avs_address >= ADDR_SWITCH0 && avs_address <= ADDR_SWITCH3 &&
              avs_address[1:0] == 2'b00) begin
            st_next.sw_pt[avs_address[3:2]] = avs_writedata[15:0];
          end
        end
      endcase
    end

    st_next.sq_out = st_reg.sq_src ?
                     {sens_a[1], !sens_a[1], sens_b[1], !sens_b[1]} :
                     {sens_a[0], !sens_a[0], sens_b[0], !sens_b[0]};
    st_next.sq_oe = 1'b1;

    // Each control output: bit 0 invert, bit 1 switch below point, bit 2 sensor 2.
    for (int i = 0; i < 4; i++) begin
      sel_freq = st_reg.out_cfg[4*i+2] ? st_reg.freq2 : st_reg.freq1;
      sel_freq_hi = sel_freq > st_reg.sw_pt[i];
      st_next.ctl_out[i] = (sel_freq_hi ^ st_reg.out_cfg[4*i+1]) ^ st_reg.out_cfg[4*i];
    end
    st_next.an_code = st_next.an_val;

    // Safe reaction of square, analog and control outputs at once while the error is latched.
    if (st_next.err) begin
      st_next.sq_out = 4'h0;
      st_next.sq_oe = 1'b0;
      st_next.an_code = DAC_ZERO;
      st_next.ctl_out = 4'h0;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.strip_mode <= STRIP_RST;
      st_reg.op_mode <= OP_MODE_RST;
      st_reg.filt_len <= FILT_LEN_RST;
      st_reg.an_start <= AN_START_RST;
      st_reg.an_end <= AN_END_RST;
      // The scaled value starts at the live floor; the output itself starts at zero.
      st_reg.an_val <= DAC_4MA;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs from the state register; waitrequest and the splitter enable decode are combinational.
  assign avs_readdata = st_reg.rdata;
  assign avs_waitrequest = req && !st_reg.ack;
  assign sine_cosine_splitter_enable = is_sincos(st_reg.op_mode);
  assign sine_cosine_splitter_offset_shift = st_reg.err;
  assign square_wave_out = st_reg.sq_out;
  assign square_wave_oe = {4{st_reg.sq_oe}};
  assign analog_current_code = st_reg.an_code;
  assign control_output_strip = st_reg.ctl_out;

endmodule

/* File: rtl/safety_io_pkg.sv */
package safety_io_pkg;

  // Clock and measurement timing.
  localparam int          CLK_FREQ_HZ  = 50_000_000;   // System clock rate in hertz.
  localparam int          GATE_TIME_US = 1000;         // Frequency gate window in microseconds.
  localparam int          GATE_CYCLES  = GATE_TIME_US * (CLK_FREQ_HZ / 1_000_000);

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [5:0]  ADDR_CTRL      = 6'h00;
  localparam logic [5:0]  ADDR_STATUS    = 6'h04;
  localparam logic [5:0]  ADDR_ERR_CLEAR = 6'h08;
  localparam logic [5:0]  ADDR_AN_START  = 6'h0c;
  localparam logic [5:0]  ADDR_AN_END    = 6'h10;
  localparam logic [5:0]  ADDR_FREQ1     = 6'h14;
  localparam logic [5:0]  ADDR_FREQ2     = 6'h18;
  localparam logic [5:0]  ADDR_OUT_CFG   = 6'h1c;
  localparam logic [5:0]  ADDR_SWITCH0   = 6'h20;
  localparam logic [5:0]  ADDR_SWITCH3   = 6'h2c;

  // Reset values.
  localparam logic [3:0]  OP_MODE_RST   = 4'h0;
  localparam logic [2:0]  STRIP_RST     = 3'h4;
  localparam logic [7:0]  FILT_LEN_RST  = 8'h04;
  localparam logic [15:0] AN_START_RST  = 16'h0000;
  localparam logic [15:0] AN_END_RST    = 16'hffff;

  // Control strip configurations.
  localparam logic [2:0]  STRIP_QUAD    = 3'h0;
  localparam logic [2:0]  STRIP_SINGLE  = 3'h1;
  localparam logic [2:0]  STRIP_INVERSE = 3'h2;
  localparam logic [2:0]  STRIP_HOMOG   = 3'h3;
  localparam logic [2:0]  STRIP_FOUR    = 3'h4;
  localparam logic [2:0]  STRIP_MIX_HOM = 3'h5;
  localparam logic [2:0]  STRIP_MIX_INV = 3'h6;

  // Analog output codes of a 12-bit current DAC spanning 0 to 20 mA.
  localparam logic [11:0] DAC_ZERO  = 12'h000;
  localparam logic [11:0] DAC_4MA   = 12'h333;
  localparam logic [11:0] DAC_20MA  = 12'hfff;
  localparam logic [11:0] DAC_SPAN  = 12'hccc;
  localparam logic [4:0]  DIV_STEPS = 5'h1c;

  // Raw pins gathered for synchronisation; differential groups are {a, a_n, b, b_n}.
  typedef struct packed {
    logic [3:0] strip;
    logic [3:0] diff1;
    logic [3:0] diff2;
    logic       sin_sign;
    logic       cos_sign;
    logic       sincos_fault;
    logic       loop_open;
  } pins_t;

  // Whole state of the block.
  typedef struct packed {
    pins_t             sync1;
    pins_t             sync2;
    logic [1:0]        prev_a;
    logic [31:0]       gate;
    logic [15:0]       cnt1;
    logic [15:0]       cnt2;
    logic [15:0]       freq1;
    logic [15:0]       freq2;
    logic [7:0]        mis1;
    logic [7:0]        mis2;
    logic [3:0]        op_mode;
    logic [2:0]        strip_mode;
    logic              sq_src;
    logic              an_src;
    logic [7:0]        filt_len;
    logic [15:0]       an_start;
    logic [15:0]       an_end;
    logic [11:0]       out_cfg;
    logic [3:0][15:0]  sw_pt;
    logic              err;
    logic [4:0]        cause;
    logic              ack;
    logic [31:0]       rdata;
    logic              div_busy;
    logic [4:0]        div_cnt;
    logic [27:0]       num;
    logic [16:0]       rem;
    logic [15:0]       den;
    logic [27:0]       quo;
    logic [11:0]       an_val;
    logic [11:0]       an_code;
    logic [3:0]        sq_out;
    logic              sq_oe;
    logic [3:0]        ctl_out;
  } state_t;

endpackage
